// ===== rtl/wcpr_carrier.sv
// carrier period reload block: axi4-lite registers, carrier counter, phase outputs
// assumes clk is the oscillator input and inputs are synchronous to it
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
module wcpr_carrier
    import wcpr_pkg::*;
#(
    parameter int NPHASE = 3
)
(
    input wire logic clk, // oscillator input clock
    input wire logic resetn, // async reset, active low
    input wire logic [12:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [12:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [NPHASE-1:0] phaseOut, // phase outputs, active high
    output logic carrierStart // pulse at each carrier boundary
);
    if (NPHASE < 1 || NPHASE > 8)
    begin : g_chk
        $error("NPHASE must be 1 to 8");
    end

    typedef struct packed {
        logic awHeld;
        logic [12:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [15:0] reload;
        logic [NPHASE*16-1:0] cmp;
        logic enable;
        logic center;
        logic [15:0] actReload;
        logic [15:0] cnt;
        logic down;
        logic tick;
        logic boundary;
    } wcpr_state_s;

    wcpr_state_s st;
    wcpr_state_s next_st;
    logic [NPHASE*16-1:0] actCmp;
    logic loadShadow;

    // byte-lane merge of a write into a 16-bit field
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // shadows load while stopped or as the counter restarts
    assign loadShadow = !st.enable || st.actReload == 16'h0000 || st.boundary;

    always_comb
    begin
        logic [12:0] a;
        logic hit;
        logic last;
        a = st.awAddr;
        hit = 1'b0;
        last = 1'b0;
        next_st = st;
        next_st.boundary = 1'b0;
        // write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_st.wHeld = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (st.awHeld && st.wHeld)
        begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bValid = 1'b1;
            if (a == RELOAD_OFS)
            begin
                hit = 1'b1;
                next_st.reload = merge16(st.reload, st.wData, st.wStrb);
            end
            if (a == CTRL_OFS)
            begin
                hit = 1'b1;
                if (st.wStrb[0])
                begin
                    next_st.enable = st.wData[CTRL_EN_BIT];
                    next_st.center = st.wData[CTRL_CENTER_BIT];
                end
            end
            if (a == STAT_OFS)
            begin
                hit = 1'b1; // read-only, write ignored
            end
            for (int i = 0; i < NPHASE; i++)
            begin
                if (a == CMP_BASE_OFS + 13'(4 * i))
                begin
                    hit = 1'b1;
                    next_st.cmp[i*16 +: 16] = merge16(st.cmp[i*16 +: 16], st.wData, st.wStrb);
                end
            end
            next_st.bResp = hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (st.bValid && s_axi_bready)
        begin
            next_st.bValid = 1'b0;
        end
        // read channel: answer one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_st.rValid = 1'b1;
            next_st.rResp = RESP_OKAY;
            next_st.rData = 32'h00000000;
            if (s_axi_araddr == RELOAD_OFS)
            begin
                next_st.rData = {16'h0000, st.reload};
            end
            else if (s_axi_araddr == CTRL_OFS)
            begin
                next_st.rData[CTRL_EN_BIT] = st.enable;
                next_st.rData[CTRL_CENTER_BIT] = st.center;
            end
            else if (s_axi_araddr == STAT_OFS)
            begin
                next_st.rData = {15'h0000, st.down, st.cnt};
            end
            else
            begin
                next_st.rResp = RESP_SLVERR;
                for (int i = 0; i < NPHASE; i++)
                begin
                    if (s_axi_araddr == CMP_BASE_OFS + 13'(4 * i))
                    begin
                        next_st.rResp = RESP_OKAY;
                        next_st.rData = {16'h0000, st.cmp[i*16 +: 16]};
                    end
                end
            end
        end
        else if (st.rValid && s_axi_rready)
        begin
            next_st.rValid = 1'b0;
        end
        // carrier counter: one step every second clock, so edge mode
        // spans two clocks per count and center mode four
        if (loadShadow)
        begin
            next_st.actReload = st.reload;
        end
        if (!st.enable || st.actReload == 16'h0000)
        begin
            next_st.cnt = 16'h0000;
            next_st.down = 1'b0;
            next_st.tick = 1'b0;
        end
        else
        begin
            next_st.tick = !st.tick;
            if (st.tick)
            begin
                if (!st.center)
                begin
                    last = (st.cnt >= st.actReload - 16'h0001);
                    next_st.cnt = last ? 16'h0000 : st.cnt + 16'h0001;
                    next_st.down = 1'b0;
                end
                else if (!st.down)
                begin
                    next_st.cnt = st.cnt + 16'h0001;
                    next_st.down = (st.cnt + 16'h0001 == st.actReload);
                end
                else
                begin
                    last = (st.cnt == 16'h0001);
                    next_st.cnt = st.cnt - 16'h0001;
                    next_st.down = !last;
                end
                next_st.boundary = last;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0; // reload and compares reset to zero
        end
        else
        begin
            st <= next_st;
        end
    end

    // one output stage per phase
    for (genvar i = 0; i < NPHASE; i++)
    begin : g_phase
        wcpr_phase_out u_phase (
            .clk(clk),
            .resetn(resetn),
            .load(loadShadow),
            .compare(st.cmp[i*16 +: 16]),
            .limit(st.reload),
            .count(st.cnt),
            .phaseOut(phaseOut[i]),
            .activeCmp(actCmp[i*16 +: 16])
        );
    end

    assign s_axi_awready = !st.awHeld && !st.bValid;
    assign s_axi_wready = !st.wHeld && !st.bValid;
    assign s_axi_bvalid = st.bValid;
    assign s_axi_bresp = st.bResp;
    assign s_axi_arready = !st.rValid;
    assign s_axi_rvalid = st.rValid;
    assign s_axi_rdata = st.rData;
    assign s_axi_rresp = st.rResp;
    assign carrierStart = st.boundary;

    // checks on the reload write, counter and outputs
    property p_reload_wr;
        @(posedge clk) disable iff (!resetn)
        (st.awHeld && st.wHeld && st.awAddr == RELOAD_OFS && st.wStrb[1:0] == 2'h3)
            |=> st.reload == $past(st.wData[15:0]);
    endproperty
    a_reload_wr: assert property (p_reload_wr) else $error("reload write lost");

    property p_edge_wrap;
        @(posedge clk) disable iff (!resetn)
        (st.enable && !st.center && st.tick && st.actReload != 16'h0000 && st.cnt == st.actReload - 16'h0001)
            |=> st.cnt == 16'h0000 && st.boundary;
    endproperty
    a_edge_wrap: assert property (p_edge_wrap) else $error("edge counter wrap wrong");

    property p_half_rate;
        @(posedge clk) disable iff (!resetn)
        (st.enable && st.actReload != 16'h0000 && !st.tick && $stable(st.actReload))
            |=> $stable(st.cnt);
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("counter stepped off rate");

    property p_center_turn;
        @(posedge clk) disable iff (!resetn)
        (st.enable && st.center && st.tick && !st.down && st.cnt + 16'h0001 == st.actReload)
            |=> st.down ##2 (st.cnt == $past(st.cnt, 2) - 16'h0001);
    endproperty
    a_center_turn: assert property (p_center_turn) else $error("center turn wrong");

    property p_cnt_bound;
        @(posedge clk) disable iff (!resetn)
        st.enable && st.actReload != 16'h0000 && $stable(st.actReload) |-> st.cnt <= st.actReload;
    endproperty
    a_cnt_bound: assert property (p_cnt_bound) else $error("counter beyond reload");

    property p_cmp_clip;
        @(posedge clk) disable iff (!resetn)
        $rose(loadShadow) |=> actCmp[15:0] <= $past(st.reload);
    endproperty
    a_cmp_clip: assert property (p_cmp_clip) else $error("compare above reload");

    property p_out_span;
        @(posedge clk) disable iff (!resetn)
        $past(st.cnt) < actCmp[15:0] && $stable(actCmp[15:0]) |-> phaseOut[0];
    endproperty
    a_out_span: assert property (p_out_span) else $error("phase not asserted");

    c_edge_wrap: cover property (@(posedge clk) disable iff (!resetn) st.boundary && !st.center);
    c_center_wrap: cover property (@(posedge clk) disable iff (!resetn) st.boundary && st.center);
    c_phase_on: cover property (@(posedge clk) disable iff (!resetn) $rose(phaseOut[0]));
endmodule // wcpr_carrier

// ===== rtl/wcpr_pkg.sv
// constants for the carrier period reload block and its register map
// assumes a 32-bit axi4-lite slave port with 13-bit byte addresses
package wcpr_pkg;
    localparam int ADDR_W = 13;
    // register byte addresses
    localparam logic [12:0] RELOAD_OFS = 13'h1fc8;
    localparam logic [12:0] CMP_BASE_OFS = 13'h1fd0; // one word per phase
    localparam logic [12:0] CTRL_OFS = 13'h1fe0;
    localparam logic [12:0] STAT_OFS = 13'h1fe4;
    // reset values
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'h0000;
    // control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CENTER_BIT = 1;
    // status fields
    localparam int STAT_DOWN_BIT = 16;
    // period multipliers per alignment mode
    localparam int MULT_EDGE = 2;
    localparam int MULT_CENTER = 4;
    // oscillator clocks per counter step, derived from the edge multiplier
    localparam int CLK_PER_STEP = MULT_EDGE / 1;
    // counter steps per count value in center mode (up then down)
    localparam int CENTER_SWEEPS = MULT_CENTER / MULT_EDGE;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/wcpr_phase_out.sv
// one phase output: shadowed compare and asserted level
// assumes load from the parent at carrier boundaries and while the carrier is stopped
`timescale 1ns/10ps
module wcpr_phase_out
    import wcpr_pkg::*;
(
    input wire logic clk, // oscillator input clock
    input wire logic resetn, // async reset, active low
    input wire logic load, // take new compare at boundary
    input wire logic [15:0] compare, // software compare value
    input wire logic [15:0] limit, // reload value that will be active
    input wire logic [15:0] count, // carrier counter
    output logic phaseOut, // asserted level
    output logic [15:0] activeCmp // compare in force
);
    typedef struct packed {
        logic [15:0] cmp;
        logic out;
    } wcpr_phase_s;

    wcpr_phase_s st;
    wcpr_phase_s next_st;

    // clipping keeps duty at most one hundred percent
    always_comb
    begin
        next_st = st;
        if (load)
        begin
            next_st.cmp = (compare > limit) ? limit : compare;
        end
        // output held for a fixed count span, independent of reload
        next_st.out = (count < st.cmp);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '{cmp: CMP_RST, out: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign phaseOut = st.out;
    assign activeCmp = st.cmp;
endmodule // wcpr_phase_out

// ===== tb/testbench.sv
// self-checking bench for the carrier period reload block over axi4-lite
// assumes the default three phases and a 25 MHz oscillator clock
`timescale 1ns/10ps
module testbench
    import wcpr_pkg::*;
;
    logic clk;
    logic resetn;
    logic [12:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [12:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic [2:0] phaseOut;
    logic carrierStart;
    int mismatches = 0;
    int testsRun = 0;
    int period;
    int highCnt[3];
    logic [31:0] rd;
    logic [1:0] rs;
    int cmpVal[3] = '{2, 5, 7};

    wcpr_carrier #(.NPHASE(3)) dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .phaseOut(phaseOut), .carrierStart(carrierStart));

    // 40 ns oscillator clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        testsRun++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && testsRun > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // readies are sampled at the falling edge, where they have settled
    task automatic axiWrite(input logic [12:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        logic awLeft;
        logic wLeft;
        logic awGo;
        logic wGo;
        n = 0;
        awLeft = 1'b1;
        wLeft = 1'b1;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while ((awLeft || wLeft) && n < 100)
        begin
            @(negedge clk);
            awGo = awLeft && (s_axi_awready === 1'b1);
            wGo = wLeft && (s_axi_wready === 1'b1);
            @(posedge clk);
            if (awGo)
                s_axi_awvalid <= 1'b0;
            if (wGo)
                s_axi_wvalid <= 1'b0;
            awLeft = awLeft && !awGo;
            wLeft = wLeft && !wGo;
            n++;
        end
        do
        begin
            @(negedge clk);
            n++;
        end
        while (s_axi_bvalid !== 1'b1 && n < 200);
        if (n >= 200)
            check(32'h0, 32'h1, "write response timeout");
        resp = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [12:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        logic arLeft;
        n = 0;
        arLeft = 1'b1;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (arLeft && n < 100)
        begin
            @(negedge clk);
            n++;
            if (s_axi_arready === 1'b1)
            begin
                @(posedge clk);
                s_axi_arvalid <= 1'b0;
                arLeft = 1'b0;
            end
        end
        do
        begin
            @(negedge clk);
            n++;
        end
        while (s_axi_rvalid !== 1'b1 && n < 200);
        if (n >= 200)
            check(32'h0, 32'h1, "read data timeout");
        d = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic waitStart();
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (carrierStart !== 1'b1 && n < 1000);
        if (n >= 1000)
            check(32'h0, 32'h1, "no carrier boundary");
    endtask

    // skips boundaries so shadowed values are in force, then times one period
    task automatic measure(input int skip);
        for (int k = 0; k <= skip; k++)
            waitStart();
        period = 0;
        highCnt = '{0, 0, 0};
        do
        begin
            @(negedge clk);
            period++;
            for (int i = 0; i < 3; i++)
                highCnt[i] += int'(phaseOut[i] === 1'b1);
        end
        while (carrierStart !== 1'b1 && period < 1000);
    endtask

    // main sequence
    initial
    begin
        resetn = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        axiRead(RELOAD_OFS, rd, rs);
        check(rd, 32'h0, "reload after reset");
        axiWrite(RELOAD_OFS, 32'hffffffff, rs);
        axiRead(RELOAD_OFS, rd, rs);
        check(rd, 32'h0000ffff, "reload field width");
        check(32'(rs), 32'(RESP_OKAY), "reload read response");
        axiRead(13'h0004, rd, rs);
        check(rd, 32'h0, "unmapped read data");
        check(32'(rs), 32'(RESP_SLVERR), "unmapped read response");
        axiWrite(13'h0004, 32'h1234, rs);
        check(32'(rs), 32'(RESP_SLVERR), "unmapped write response");
        // edge aligned, reload 5, last compare above reload
        axiWrite(RELOAD_OFS, 32'd5, rs);
        for (int i = 0; i < 3; i++)
            axiWrite(CMP_BASE_OFS + 13'(4 * i), 32'(cmpVal[i]), rs);
        axiWrite(CTRL_OFS, 32'(1 << CTRL_EN_BIT), rs);
        // register keeps the written compare, only the value in force is clipped
        axiRead(CMP_BASE_OFS + 13'h8, rd, rs);
        check(rd, 32'd7, "compare register readback");
        measure(1);
        check(32'(period), 32'(MULT_EDGE * 5), "edge period");
        check(32'(highCnt[0]), 32'(MULT_EDGE * 2), "phase 0 high time");
        check(32'(highCnt[1]), 32'(MULT_EDGE * 5), "phase 1 high time");
        check(32'(highCnt[2]), 32'(MULT_EDGE * 5), "clipped phase high time");
        // longer reload alone: same asserted time, smaller duty
        axiWrite(RELOAD_OFS, 32'd10, rs);
        measure(2);
        check(32'(period), 32'(MULT_EDGE * 10), "period after reload change");
        check(32'(highCnt[0]), 32'(MULT_EDGE * 2), "asserted time kept");
        check(32'(highCnt[1]), 32'(MULT_EDGE * 5), "phase 1 duty halves");
        // scaled update right after a boundary keeps the duty
        waitStart();
        axiWrite(RELOAD_OFS, 32'd20, rs);
        axiWrite(CMP_BASE_OFS, 32'd4, rs);
        axiWrite(CMP_BASE_OFS + 13'h4, 32'd10, rs);
        measure(2);
        check(32'(period), 32'(MULT_EDGE * 20), "scaled period");
        check(32'(highCnt[0]), 32'(MULT_EDGE * 4), "scaled phase 0");
        check(32'(highCnt[1]), 32'(MULT_EDGE * 10), "scaled phase 1");
        // center aligned doubles the multiplier
        axiWrite(CTRL_OFS, 32'(1 << CTRL_EN_BIT) | 32'(1 << CTRL_CENTER_BIT), rs);
        axiRead(CTRL_OFS, rd, rs);
        check(rd, 32'(1 << CTRL_EN_BIT) | 32'(1 << CTRL_CENTER_BIT), "control readback");
        measure(2);
        check(32'(period), 32'(MULT_CENTER * 20), "center period");
        // zero reload stops the carrier once the period ends
        axiWrite(RELOAD_OFS, 32'd0, rs);
        repeat (200) @(negedge clk);
        period = 0;
        repeat (200)
        begin
            @(negedge clk);
            period += int'(carrierStart !== 1'b0 || phaseOut !== 3'h0);
        end
        check(32'(period), 32'd0, "stopped carrier quiet");
        // a stopped counter rests at zero, counting up
        axiRead(STAT_OFS, rd, rs);
        check(rd, 32'h0, "stopped counter status");
        report_and_stop();
    end

    // a hang costs far more than the roughly 1100 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule // testbench
